// file: shared/spio_cfg.svh
// register map and reset values of the shared parallel i/o port
`ifndef SPIO_CFG_SVH
`define SPIO_CFG_SVH
`define SPIO_W 16
`define SPIO_IMPL_MASK 16'h3FFF
`define SPIO_ANA_RST 16'h0000
`define SPIO_DIR_RST 16'hFFFF
`define SPIO_LAT_RST 16'h0000
`define SPIO_ODC_RST 16'h0000
`define SPIO_ADR_DIR 4'h0
`define SPIO_ADR_PIN 4'h1
`define SPIO_ADR_LAT 4'h2
`define SPIO_ADR_ODC 4'h3
`define SPIO_ADR_ANA 4'h4
`define SPIO_ADR_PDRV 4'h5
`define SPIO_ZERO 16'h0000
`endif

// file: shared/spio_pkg.sv
// types of the shared parallel i/o port
package spio_pkg;
  typedef enum logic [1:0] {
    SPIO_IDLE = 2'b00,
    SPIO_ACK = 2'b01
  } spio_bus_t;
endpackage : spio_pkg

// file: hdl/spio_sync.sv
// three-stage synchroniser for pin levels with agreement filter
`include "spio_cfg.svh"
module spio_sync
  import spio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [`SPIO_W-1:0] d_i,
  output logic [`SPIO_W-1:0] q_o
);
  logic [`SPIO_W-1:0] s1_ff, s2_ff, s3_ff, q_ff;
  logic [`SPIO_W-1:0] nxt_q;

  // a change counts only once stages two and three agree
  always_comb begin
    nxt_q = q_ff;
    for (int i = 0; i < `SPIO_W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_q[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= `SPIO_ZERO;
      s2_ff <= `SPIO_ZERO;
      s3_ff <= `SPIO_ZERO;
      q_ff <= `SPIO_ZERO;
    end else if (ce_i) begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;
endmodule : spio_sync

// file: hdl/spio_port.sv
// shared parallel i/o port with wishbone register access
`include "spio_cfg.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// - per pin, two muxes pick peripheral or port for data and enable
// - an enabled, driving peripheral always wins the pin over the port bit
// - active peripheral drive disables port driver; pin still readable
// - enabled but idle peripheral lets the port drive the pin
// - port output never loops into the sharing peripheral's input
// - direction bit 1 means input, 0 means output
// - every reset makes all pins inputs
// - latch register reads the latch, writes the latch
// - pin-state reads pin levels, writes go to the latch
// - unimplemented bits read zero in latch, direction, pin-state
// - open-drain bit set makes the port drive low only, float high; an owning peripheral still drives both levels
// - input-only shared pins are plain port pins
// - analog pins read zero in pin-state
module spio_port
  import spio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [`SPIO_W-1:0] pin_i,
  output logic [`SPIO_W-1:0] pin_o,
  output logic [`SPIO_W-1:0] pin_oe_o,
  input wire logic [`SPIO_W-1:0] per_en_i,
  input wire logic [`SPIO_W-1:0] per_drv_i,
  input wire logic [`SPIO_W-1:0] per_out_i,
  output logic [`SPIO_W-1:0] per_in_o
);
  localparam logic [`SPIO_W-1:0] IMPL = `SPIO_IMPL_MASK;

  //////////////////////////////////////////////////////////////////////////
  // registers
  logic [`SPIO_W-1:0] direction_reg_ff, output_latch_reg_ff;
  logic [`SPIO_W-1:0] open_drain_ctrl_reg_ff, analog_sel_ff;
  logic [`SPIO_W-1:0] nxt_dir, nxt_lat, nxt_odc, nxt_ana;
  logic [31:0] rd_ff, nxt_rd;
  logic ack_ff, nxt_ack;
  spio_bus_t st_ff, nxt_st;
  logic [`SPIO_W-1:0] pin_sync, pin_state_reg, own;
  logic [`SPIO_W-1:0] wmask, wdat;
  logic hit;

  spio_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(pin_i),
    .q_o(pin_sync)
  );

  assign pin_state_reg = pin_sync & ~analog_sel_ff & IMPL;
  assign own = per_en_i & per_drv_i;
  assign hit = wb_cyc_i & wb_stb_i & (st_ff == SPIO_IDLE);
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wdat = wb_dat_i[`SPIO_W-1:0];

  // single-wait ack; the request is taken in the idle state only
  always_comb begin
    nxt_dir = direction_reg_ff;
    nxt_lat = output_latch_reg_ff;
    nxt_odc = open_drain_ctrl_reg_ff;
    nxt_ana = analog_sel_ff;
    nxt_rd = 32'h00000000;
    nxt_ack = 1'b0;
    nxt_st = SPIO_IDLE;
    case (st_ff)
      SPIO_IDLE: begin
        if (hit) begin
          nxt_ack = 1'b1;
          nxt_st = SPIO_ACK;
          if (wb_we_i) begin
            case (wb_adr_i[5:2])
              `SPIO_ADR_DIR: nxt_dir = ((direction_reg_ff & ~wmask) | (wdat & wmask)) & IMPL;
              `SPIO_ADR_LAT,
              `SPIO_ADR_PIN: nxt_lat = ((output_latch_reg_ff & ~wmask) | (wdat & wmask)) & IMPL;
              `SPIO_ADR_ODC: nxt_odc = ((open_drain_ctrl_reg_ff & ~wmask) | (wdat & wmask)) & IMPL;
              `SPIO_ADR_ANA: nxt_ana = ((analog_sel_ff & ~wmask) | (wdat & wmask)) & IMPL;
              default: nxt_ana = analog_sel_ff;
            endcase
          end else begin
            case (wb_adr_i[5:2])
              `SPIO_ADR_DIR: nxt_rd = {16'h0000, direction_reg_ff};
              `SPIO_ADR_PIN: nxt_rd = {16'h0000, pin_state_reg};
              `SPIO_ADR_LAT: nxt_rd = {16'h0000, output_latch_reg_ff};
              `SPIO_ADR_ODC: nxt_rd = {16'h0000, open_drain_ctrl_reg_ff};
              `SPIO_ADR_ANA: nxt_rd = {16'h0000, analog_sel_ff};
              `SPIO_ADR_PDRV: nxt_rd = {16'h0000, own & IMPL};
              default: nxt_rd = 32'h00000000;
            endcase
          end
        end
      end
      SPIO_ACK: nxt_st = SPIO_IDLE;
      default: nxt_st = SPIO_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direction_reg_ff <= `SPIO_DIR_RST & IMPL;
      output_latch_reg_ff <= `SPIO_LAT_RST;
      open_drain_ctrl_reg_ff <= `SPIO_ODC_RST;
      analog_sel_ff <= `SPIO_ANA_RST & IMPL;
      rd_ff <= 32'h00000000;
      ack_ff <= 1'b0;
      st_ff <= SPIO_IDLE;
    end else if (ce_i) begin
      direction_reg_ff <= nxt_dir;
      output_latch_reg_ff <= nxt_lat;
      open_drain_ctrl_reg_ff <= nxt_odc;
      analog_sel_ff <= nxt_ana;
      rd_ff <= nxt_rd;
      ack_ff <= nxt_ack;
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = rd_ff;
  assign wb_ack_o = ack_ff;

  //////////////////////////////////////////////////////////////////////////
  // pin muxes, registered so every output comes from a flop
  logic [`SPIO_W-1:0] pin_ff, oe_ff, pin_in_ff;
  logic [`SPIO_W-1:0] nxt_pin, nxt_oe, nxt_pin_in;

  always_comb begin
    nxt_pin = `SPIO_ZERO;
    nxt_oe = `SPIO_ZERO;
    nxt_pin_in = `SPIO_ZERO;
    for (int i = 0; i < `SPIO_W; i++) begin
      if (own[i]) begin
        nxt_pin[i] = per_out_i[i];
        nxt_oe[i] = 1'b1;
      end else begin
        nxt_pin[i] = open_drain_ctrl_reg_ff[i] ? 1'b0 : output_latch_reg_ff[i];
        nxt_oe[i] = ~direction_reg_ff[i] &
                    ~(open_drain_ctrl_reg_ff[i] & output_latch_reg_ff[i]);
      end
      // peripheral sees the pin only when the port is not driving it
      nxt_pin_in[i] = (nxt_oe[i] & ~own[i]) ? 1'b0 : pin_sync[i];
    end
    nxt_pin = nxt_pin & IMPL;
    nxt_oe = nxt_oe & IMPL;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ff <= `SPIO_ZERO;
      oe_ff <= `SPIO_ZERO;
      pin_in_ff <= `SPIO_ZERO;
    end else if (ce_i) begin
      pin_ff <= nxt_pin;
      oe_ff <= nxt_oe;
      pin_in_ff <= nxt_pin_in;
    end
  end

  assign pin_o = pin_ff;
  assign pin_oe_o = oe_ff;
  assign per_in_o = pin_in_ff;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_req;
    wb_cyc_i && wb_stb_i && st_ff == SPIO_IDLE;
  endsequence

  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##0 s_req |=> wb_ack_o) else $error("ack missing after request");
  a_reset_inputs: assert property (@(posedge clk_i)
    rst_i |=> direction_reg_ff == (`SPIO_DIR_RST & IMPL)) else $error("dir not input");
  a_per_priority: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && (own & IMPL) != 0 |=> (pin_oe_o & $past(own & IMPL)) == $past(own & IMPL))
    else $error("peripheral lost pin");
  a_per_data: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (pin_o & $past(own & IMPL)) == ($past(per_out_i & own) & IMPL))
    else $error("peripheral data wrong");
  a_dir_input: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (pin_oe_o & ~$past(own) & $past(direction_reg_ff)) == 0)
    else $error("input pin driven");
  a_odc_high: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (pin_oe_o & pin_o & ~$past(own) & $past(open_drain_ctrl_reg_ff)) == 0)
    else $error("open drain drove high");
  a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    ((direction_reg_ff | output_latch_reg_ff | pin_state_reg) & ~IMPL) == 0)
    else $error("unimplemented bit set");
  a_pin_write: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##0 s_req ##0 (wb_we_i && wb_adr_i[5:2] == `SPIO_ADR_PIN && wb_sel_i[1:0] == 2'b11)
    |=> output_latch_reg_ff == ($past(wb_dat_i[`SPIO_W-1:0]) & IMPL))
    else $error("pin write missed latch");
  a_analog_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (pin_state_reg & analog_sel_ff) == 0) else $error("analog pin read nonzero");
  a_no_loop: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> (per_in_o & $past(nxt_oe & ~own)) == 0) else $error("loop through");
endmodule : spio_port

// file: test/spio_pin_model.sv
// pad model: external pull-ups on every pin of the port
`include "spio_cfg.svh"
module spio_pin_model (
  input wire logic [`SPIO_W-1:0] pin_o_i,
  input wire logic [`SPIO_W-1:0] pin_oe_i,
  output logic [`SPIO_W-1:0] pin_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released pad floats up, so open-drain highs come from the pull-up
  assign pin_lvl_o = (pin_o_i & pin_oe_i) | ~pin_oe_i;
endmodule : spio_pin_model

// file: test/shared_parallel_io_port_tb.sv
// self-checking bench of the shared parallel i/o port
`include "spio_cfg.svh"
module shared_parallel_io_port_tb
  import spio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [`SPIO_W-1:0] pin_i, pin_o, pin_oe_o, per_en_i, per_drv_i, per_out_i, per_in_o;
  int num_errors = 0;
  int checked = 0;
  localparam logic [5:0] A_DIR = 6'h00, A_PIN = 6'h04, A_LAT = 6'h08;
  localparam logic [5:0] A_ODC = 6'h0C, A_ANA = 6'h10, A_NONE = 6'h18;
  spio_port uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .per_en_i(per_en_i), .per_drv_i(per_drv_i),
    .per_out_i(per_out_i), .per_in_o(per_in_o));
  spio_pin_model pads (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pin_lvl_o(pin_i));
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // entered just after a rising edge; the ack edge is the only one that counts
  task automatic wb(input logic we, input logic [5:0] adr, input logic [15:0] wd,
    output logic [15:0] rd);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, 16'h0000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o[15:0];
    if (n >= 20) chk("ack", 16'h0001, 16'h0000);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [5:0] adr, input logic [15:0] wd);
    logic [15:0] d;
    wb(1'b1, adr, wd, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [5:0] adr, input logic [15:0] exp);
    logic [15:0] d;
    wb(1'b0, adr, 16'h0000, d);
    chk(nm, exp, d);
  endtask : rdchk
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk("dir", A_DIR, 16'h3FFF);
    rdchk("lat", A_LAT, 16'h0000);
    rdchk("odc", A_ODC, 16'h0000);
    rdchk("unmapped", A_NONE, 16'h0000);
    wr(A_LAT, 16'hFFFF);
    rdchk("lat", A_LAT, 16'h3FFF);
    wr(A_PIN, 16'h1234);
    rdchk("lat via pin", A_LAT, 16'h1234);
    wb_sel_i <= 4'h1;
    wr(A_LAT, 16'hABCD);
    rdchk("lat low lane", A_LAT, 16'h12CD);
    wb_sel_i <= 4'h3;
    wr(A_LAT, 16'h1234);
    rdchk("lat restore", A_LAT, 16'h1234);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_out;
    wr(A_DIR, 16'h0000);
    repeat (8) @(posedge clk_i);
    chk("oe", 16'h3FFF, pin_oe_o & 16'h3FFF);
    chk("pin_o", 16'h1234, pin_o & 16'h3FFF);
    rdchk("pin", A_PIN, 16'h1234);
    wr(A_ANA, 16'h0004);
    rdchk("pin analog", A_PIN, 16'h1230);
    wr(A_ANA, 16'h0000);
    $display("t_out done");
  endtask : t_out
  task automatic t_periph;
    {per_en_i, per_drv_i, per_out_i} <= {16'h00F0, 16'h0030, 16'h0010};
    repeat (8) @(posedge clk_i);
    chk("oe", 16'h3FFF, pin_oe_o & 16'h3FFF);
    chk("pin_o", 16'h1214, pin_o & 16'h3FFF);
    chk("per_in", 16'h0010, per_in_o & 16'h3FFF);
    rdchk("pin", A_PIN, 16'h1214);
    {per_en_i, per_drv_i, per_out_i} <= 48'h0;
    $display("t_periph done");
  endtask : t_periph
  task automatic t_odc;
    wr(A_LAT, 16'h000F);
    wr(A_ODC, 16'h00FF);
    repeat (8) @(posedge clk_i);
    chk("oe od", 16'h00F0, pin_oe_o & 16'h00FF);
    chk("pin_o od", 16'h0000, pin_o & 16'h00F0);
    rdchk("pin od", A_PIN, 16'h000F);
    $display("t_odc done");
  endtask : t_odc
  task automatic t_in;
    wr(A_DIR, 16'hFFFF);
    repeat (8) @(posedge clk_i);
    chk("oe in", 16'h0000, pin_oe_o & 16'h3FFF);
    chk("per_in", 16'h3FFF, per_in_o & 16'h3FFF);
    rdchk("pin in", A_PIN, 16'h3FFF);
    wr(A_DIR, 16'h0000);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk("dir rst", A_DIR, 16'h3FFF);
    $display("t_in done");
  endtask : t_in
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    final_report();
  end
  initial begin
    {rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = {5'b11000, 6'h0, 4'h3};
    wb_dat_i = 32'h0000_0000;
    {per_en_i, per_drv_i, per_out_i} = 48'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_out();
    t_periph();
    t_odc();
    t_in();
    final_report();
  end
endmodule : shared_parallel_io_port_tb
